// ---- seq_pkg.sv ----
// constants for the instruction sequencer and program counter
package seq_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // sizes
    localparam int unsigned ADDR_W     = 12;    // program address width
    localparam int unsigned WORD_W     = 15;    // instruction word width
    localparam int unsigned LOW_W      = 8;     // low-byte width
    localparam int unsigned PHASES     = 4;     // clocks per instruction cycle
    localparam int unsigned WAKE_CLKS  = 1024;  // start-up timer length in clocks
    localparam int unsigned WAKE_W     = 11;    // start-up counter width

    ////////////////////////////////////////////////////////////////////////////////
    // fixed addresses
    localparam logic [11:0] RESET_ADDR = 12'h000;
    localparam logic [11:0] EXT_VEC    = 12'h004;
    localparam logic [11:0] TMR0_VEC   = 12'h008;
    localparam logic [11:0] TMR1_VEC   = 12'h00c;
    localparam logic [11:0] PC_STEP    = 12'h001;
    localparam logic [11:0] SKIP_STEP  = 12'h002;

    ////////////////////////////////////////////////////////////////////////////////
    // phase and reload kinds
    localparam logic [1:0] PH_FIRST    = 2'h0;
    localparam logic [1:0] PH_LAST     = 2'h3;

    typedef enum logic [2:0] {
        LD_NONE  = 3'h0,   // plain increment
        LD_JUMP  = 3'h1,   // jump, call, branch target
        LD_RET   = 3'h2,   // return from subroutine or interrupt
        LD_LOW   = 3'h3,   // low-byte write
        LD_SKIP  = 3'h4    // true conditional skip
    } load_kind_t;

endpackage : seq_pkg

// ---- phase_gen.sv ----
// four-phase generator for the instruction cycle
`timescale 1ns/1ps
module phase_gen (
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    // control
    input  wire logic       run,        // low holds the phase at the last
    // phase outputs
    output logic [1:0]      phase_q,    // current phase 0..3
    output logic            cycle_end_q // high in the last phase, low while the phase is held there
);

    logic [1:0] phase_d;
    logic       cycle_end_d;

    // next phase: wraps after four clocks
    always_comb begin
        phase_d     = seq_pkg::PH_FIRST;
        cycle_end_d = 1'b0;
        if (run) begin
            phase_d     = phase_q + 2'h1;
            cycle_end_d = (phase_d == seq_pkg::PH_LAST);
        end
    end

    // register the phase
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_q     <= seq_pkg::PH_LAST;
            cycle_end_q <= 1'b0;
        end else begin
            phase_q     <= run ? phase_d : seq_pkg::PH_LAST;
            cycle_end_q <= cycle_end_d;
        end
    end

endmodule : phase_gen

// ---- instruction_sequencer_pc.sv ----
// instruction sequencer: fetch pipeline, program counter and wake-up timer
`timescale 1ns/1ps
module instruction_sequencer_pc #(
    parameter int unsigned WAKE_CLKS = seq_pkg::WAKE_CLKS  // start-up timer length
) (
    // clock and reset
    input  wire logic                        sys_clk,
    input  wire logic                        rst_n,
    input  wire logic                        reset_n_pin,    // external reset pin
    // options and power
    input  wire logic                        rc_osc_sel,     // rc oscillator option
    input  wire logic                        halt_req,       // pulse: enter sleep
    input  wire logic                        wake_req,       // level: wake-up source
    // execute-stage decisions, valid in the last phase
    input  wire logic [2:0]                  load_kind,      // seq_pkg::load_kind_t code
    input  wire logic [seq_pkg::ADDR_W-1:0]  jump_target,    // jump, call, branch target
    input  wire logic [seq_pkg::ADDR_W-1:0]  stack_top,      // return address
    input  wire logic [seq_pkg::LOW_W-1:0]   low_byte_data,  // value written to low byte
    // interrupt requests
    input  wire logic                        ext_irq,        // enabled external request
    input  wire logic                        tmr0_irq,       // enabled timer 0 overflow
    input  wire logic                        tmr1_irq,       // enabled timer 1 overflow
    input  wire logic                        stack_full,     // stack holds four entries
    // program memory
    output logic [seq_pkg::ADDR_W-1:0]       rom_addr_q,     // fetch address
    output logic                             rom_rd_q,       // fetch strobe, one cycle
    input  wire logic [seq_pkg::WORD_W-1:0]  rom_data,       // word, valid the clock after
    // execute stage
    output logic [seq_pkg::WORD_W-1:0]       instr_q,        // instruction being executed
    output logic                             instr_valid_q,  // low during dummy cycles
    output logic [seq_pkg::ADDR_W-1:0]       instruction_pointer_q, // counter
    output logic                             irq_ack_q,      // pulse: interrupt taken
    output logic                             sleeping_q,     // halted or starting up
    // clock output pin
    output logic                             clock_out_pin_q
);

    ////////////////////////////////////////////////////////////////////////////////
    // synchronisers for the pins
    logic [1:0] rst_sync_q;   // reset pin, bit 0 is the first stage
    logic [1:0] wake_sync_q;  // wake pin
    logic       pin_rst_n;    // synchronised reset pin level
    logic       wake_lvl;     // synchronised wake level

    // two flops for each asynchronous input
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync_q  <= 2'h0;
            wake_sync_q <= 2'h0;
        end else begin
            rst_sync_q  <= {rst_sync_q[0], reset_n_pin};
            wake_sync_q <= {wake_sync_q[0], wake_req};
        end
    end

    assign pin_rst_n = rst_sync_q[1];
    assign wake_lvl  = wake_sync_q[1];

    ////////////////////////////////////////////////////////////////////////////////
    // sleep and start-up timer
    typedef enum logic [2:0] {
        ST_RUN   = 3'b001,   // executing
        ST_HALT  = 3'b010,   // sleeping
        ST_START = 3'b100    // start-up timer running
    } pwr_state_t;

    pwr_state_t              pwr_q, pwr_d;
    logic [seq_pkg::WAKE_W-1:0] wake_cnt_q, wake_cnt_d;
    logic                    running;

    localparam logic [seq_pkg::WAKE_W-1:0] WAKE_LAST =
        seq_pkg::WAKE_W'(WAKE_CLKS - 1);

    // sleep state next values
    always_comb begin
        pwr_d      = pwr_q;
        wake_cnt_d = wake_cnt_q;
        case (pwr_q)
            ST_RUN: begin
                if (halt_req) begin
                    pwr_d = ST_HALT;
                end
            end
            ST_HALT: begin
                if (wake_lvl) begin
                    pwr_d      = ST_START;
                    wake_cnt_d = '0;
                end
            end
            ST_START: begin
                // the oscillator needs time to settle before fetching resumes
                if (wake_cnt_q == WAKE_LAST) begin
                    pwr_d = ST_RUN;
                end else begin
                    wake_cnt_d = wake_cnt_q + 1'b1;
                end
            end
            default: begin
                pwr_d = ST_RUN;
            end
        endcase
        if (!pin_rst_n) begin
            pwr_d      = ST_RUN;
            wake_cnt_d = '0;
        end
    end

    // register sleep state
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pwr_q      <= ST_RUN;
            wake_cnt_q <= '0;
        end else begin
            pwr_q      <= pwr_d;
            wake_cnt_q <= wake_cnt_d;
        end
    end

    assign running = (pwr_q == ST_RUN) && pin_rst_n;

    ////////////////////////////////////////////////////////////////////////////////
    // phase generator
    logic [1:0] phase;
    logic       cycle_end;

    phase_gen u_phase (
        .sys_clk     (sys_clk),
        .rst_n       (rst_n),
        .run         (running),
        .phase_q     (phase),
        .cycle_end_q (cycle_end)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // program counter and fetch pipeline
    logic [seq_pkg::ADDR_W-1:0] pc_d, rom_addr_d;
    logic                       rom_rd_d;
    logic                       fetched_q, fetched_d;  // a word arrives this clock
    logic                       flush_q, flush_d;      // prefetched word is discarded
    logic [seq_pkg::WORD_W-1:0] pre_q, pre_d;          // prefetched word
    logic                       pre_ok_q, pre_ok_d;    // prefetch is usable
    logic [seq_pkg::WORD_W-1:0] instr_d;
    logic                       instr_valid_d, irq_ack_d;
    logic                       sleeping_d, clk_out_d;
    logic                       take_irq;

    // twelve-bit add wraps from the top address back to zero
    function automatic logic [seq_pkg::ADDR_W-1:0] pc_add(
        input logic [seq_pkg::ADDR_W-1:0] base,
        input logic [seq_pkg::ADDR_W-1:0] step
    );
        pc_add = base + step;
    endfunction : pc_add

    // interrupts are held off while the stack cannot take the return address
    assign take_irq = (ext_irq || tmr0_irq || tmr1_irq) && !stack_full;

    // counter, fetch and execute next values
    always_comb begin
        pc_d          = instruction_pointer_q;
        rom_addr_d    = rom_addr_q;
        rom_rd_d      = 1'b0;
        fetched_d     = rom_rd_q;
        flush_d       = flush_q;
        pre_d         = pre_q;
        pre_ok_d      = pre_ok_q;
        instr_d       = instr_q;
        instr_valid_d = instr_valid_q;
        irq_ack_d     = 1'b0;
        sleeping_d    = (pwr_q != ST_RUN);
        // clock out only when the rc option is selected: quarter rate while running, high while the phase is held
        clk_out_d     = rc_osc_sel && (phase_d_hi(phase));
        if (fetched_q) begin
            pre_d    = rom_data;
            pre_ok_d = !flush_q;
            flush_d  = 1'b0;
        end
        if (!pin_rst_n) begin
            pc_d          = seq_pkg::RESET_ADDR;
            rom_addr_d    = seq_pkg::RESET_ADDR;
            flush_d       = 1'b0;
            pre_ok_d      = 1'b0;
            instr_valid_d = 1'b0;
        end else if (running && phase == seq_pkg::PH_FIRST) begin
            // fetch the word at the counter, then step past it
            rom_addr_d = instruction_pointer_q;
            rom_rd_d   = 1'b1;
            pc_d       = pc_add(instruction_pointer_q, seq_pkg::PC_STEP);
        end else if (running && cycle_end) begin
            // the prefetched word becomes the executing one; a dummy cycle if dropped
            instr_d       = pre_q;
            instr_valid_d = pre_ok_q;
            // a transfer retires the word fetched behind it as a dummy cycle
            if (take_irq) begin
                if (ext_irq) begin
                    pc_d = seq_pkg::EXT_VEC;
                end else if (tmr0_irq) begin
                    pc_d = seq_pkg::TMR0_VEC;
                end else begin
                    pc_d = seq_pkg::TMR1_VEC;
                end
                irq_ack_d     = 1'b1;
                instr_valid_d = 1'b0;
            end else if (instr_valid_q) begin
                case (load_kind)
                    seq_pkg::LD_JUMP: begin
                        pc_d          = jump_target;
                        instr_valid_d = 1'b0;
                    end
                    seq_pkg::LD_RET: begin
                        pc_d          = stack_top;
                        instr_valid_d = 1'b0;
                    end
                    seq_pkg::LD_LOW: begin
                        // page bits stay, so the jump stays in the current page
                        pc_d          = {instruction_pointer_q[seq_pkg::ADDR_W-1:seq_pkg::LOW_W],
                                         low_byte_data};
                        instr_valid_d = 1'b0;
                    end
                    seq_pkg::LD_SKIP: begin
                        // the skipped word already went past the counter
                        instr_valid_d = 1'b0;
                    end
                    default: begin
                        pc_d = instruction_pointer_q;
                    end
                endcase
            end
            if (fetched_q && !pre_ok_d) begin
                flush_d = 1'b1;
            end
        end
    end

    // quarter-rate level from the phase: high for phases two and three
    function automatic logic phase_d_hi(input logic [1:0] ph);
        phase_d_hi = ph[1];
    endfunction : phase_d_hi

    // register counter and pipeline
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            instruction_pointer_q <= seq_pkg::RESET_ADDR;
            rom_addr_q            <= seq_pkg::RESET_ADDR;
            rom_rd_q              <= 1'b0;
            fetched_q             <= 1'b0;
            flush_q               <= 1'b0;
            pre_q                 <= '0;
            pre_ok_q              <= 1'b0;
            instr_q               <= '0;
            instr_valid_q         <= 1'b0;
            irq_ack_q             <= 1'b0;
            sleeping_q            <= 1'b0;
            clock_out_pin_q       <= 1'b0;
        end else begin
            instruction_pointer_q <= pc_d;
            rom_addr_q            <= rom_addr_d;
            rom_rd_q              <= rom_rd_d;
            fetched_q             <= fetched_d;
            flush_q               <= flush_d;
            pre_q                 <= pre_d;
            pre_ok_q              <= pre_ok_d;
            instr_q               <= instr_d;
            instr_valid_q         <= instr_valid_d;
            irq_ack_q             <= irq_ack_d;
            sleeping_q            <= sleeping_d;
            clock_out_pin_q       <= clk_out_d;
        end
    end

endmodule : instruction_sequencer_pc

// ---- rom_model.sv ----
// program memory model answering the sequencer's fetch strobes
`timescale 1ns/1ps
module rom_model (
    // clock
    input  wire logic        sys_clk,
    // fetch side
    input  wire logic        rom_rd,
    input  wire logic [11:0] rom_addr,
    output logic      [14:0] rom_data
);
    ////////////////////////////////////////////////////////////
    // each word carries its own address, so a wrong fetch shows up
    // outside the answer cycle the bus flips, so a late sample cannot pass
    initial rom_data = 15'h0000;
    always @(posedge sys_clk) begin
        if (rom_rd) begin
            rom_data <= {3'h5, rom_addr};
        end else begin
            rom_data <= ~rom_data;
        end
    end
endmodule : rom_model

// ---- instruction_sequencer_pc_asserts.sv ----
// port-level checks on the instruction sequencer
`timescale 1ns/1ps
module instruction_sequencer_pc_asserts #(
    parameter int unsigned WAKE_CLKS = seq_pkg::WAKE_CLKS  // start-up length
) (
    // clock and reset
    input wire logic        sys_clk,
    input wire logic        rst_n,
    input wire logic        reset_n_pin,
    // requests
    input wire logic        rc_osc_sel,
    input wire logic        wake_req,
    input wire logic [2:0]  load_kind,
    input wire logic [11:0] jump_target,
    input wire logic        ext_irq,
    input wire logic        tmr0_irq,
    input wire logic        tmr1_irq,
    input wire logic        stack_full,
    // outputs watched
    input wire logic [11:0] rom_addr_q,
    input wire logic        rom_rd_q,
    input wire logic        instr_valid_q,
    input wire logic [11:0] instruction_pointer_q,
    input wire logic        irq_ack_q,
    input wire logic        sleeping_q,
    input wire logic        clock_out_pin_q
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////
    logic [31:0] wake_cnt_q;  // cycles asleep with a wake source present
    logic        irq_any;     // any enabled request
    assign irq_any = ext_irq | tmr0_irq | tmr1_irq;
    // counter restarts whenever the wake source or sleep drops
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wake_cnt_q <= 32'h0;
        end else begin
            wake_cnt_q <= (sleeping_q && wake_req) ? wake_cnt_q + 32'h1 : 32'h0;
        end
    end
    a_fetch_spacing: assert property (rom_rd_q |=> !rom_rd_q [*3])
        else $error("fetch strobes closer than four clocks");
    a_fetch_step: assert property (
        rom_rd_q |-> instruction_pointer_q == rom_addr_q + 12'h001)
        else $error("counter not one past fetch address");
    a_dummy_len: assert property (
        ($fell(instr_valid_q) && reset_n_pin && !sleeping_q) ##1 !sleeping_q
        |-> !instr_valid_q [*3] ##1 instr_valid_q)
        else $error("dummy cycle not four clocks");
    a_jump_load: assert property (
        instr_valid_q && load_kind == 3'h1 && !irq_any && reset_n_pin
        |-> ##[1:4] instruction_pointer_q == jump_target)
        else $error("jump target not loaded");
    a_vector_ack: assert property (
        irq_ack_q |-> ##[0:4] (instruction_pointer_q inside {12'h004, 12'h008, 12'h00c}))
        else $error("acknowledge without vector");
    a_full_refuse: assert property (
        $past(stack_full) && $past(stack_full, 2) |-> !irq_ack_q)
        else $error("interrupt taken with full stack");
    a_pin_hold: assert property (
        (!reset_n_pin) [*4] |-> instruction_pointer_q == 12'h000 && !rom_rd_q)
        else $error("reset pin does not hold counter");
    a_clkout_wave: assert property (
        $rose(clock_out_pin_q) && rc_osc_sel |=> clock_out_pin_q ##1 !clock_out_pin_q)
        else $error("clock out not a quarter rate");
    a_clkout_off: assert property (!rc_osc_sel && $past(!rc_osc_sel) |-> !clock_out_pin_q)
        else $error("clock out driven without rc option");
    a_wake_time: assert property (
        $fell(sleeping_q) && reset_n_pin
        |-> wake_cnt_q >= WAKE_CLKS && wake_cnt_q <= WAKE_CLKS + 8)
        else $error("start-up time wrong");
endmodule : instruction_sequencer_pc_asserts

// ---- instruction_sequencer_pc_tb_top.sv ----
// testbench for the instruction sequencer with a program memory model
`timescale 1ns/1ps
module instruction_sequencer_pc_tb_top;
    localparam int unsigned WAKE = 8;  // short start-up keeps the run brief
    logic        sys_clk, rst_n, reset_n_pin, rc_osc_sel, halt_req, wake_req;
    logic [2:0]  load_kind;
    logic [11:0] jump_target, stack_top, rom_addr_q, instruction_pointer_q;
    logic [7:0]  low_byte_data;
    logic        ext_irq, tmr0_irq, tmr1_irq, stack_full, rom_rd_q, instr_valid_q;
    logic [14:0] rom_data, instr_q;
    logic        irq_ack_q, sleeping_q, clock_out_pin_q;
    logic [11:0] cur;  // address of the word now executing
    int          num_errors, n_tests, gap;
    ////////////////////////////////////////////////////////////
    instruction_sequencer_pc #(.WAKE_CLKS(WAKE)) i_dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .reset_n_pin(reset_n_pin),
        .rc_osc_sel(rc_osc_sel), .halt_req(halt_req), .wake_req(wake_req),
        .load_kind(load_kind), .jump_target(jump_target), .stack_top(stack_top),
        .low_byte_data(low_byte_data), .ext_irq(ext_irq), .tmr0_irq(tmr0_irq),
        .tmr1_irq(tmr1_irq), .stack_full(stack_full), .rom_addr_q(rom_addr_q),
        .rom_rd_q(rom_rd_q), .rom_data(rom_data), .instr_q(instr_q),
        .instr_valid_q(instr_valid_q), .instruction_pointer_q(instruction_pointer_q),
        .irq_ack_q(irq_ack_q), .sleeping_q(sleeping_q), .clock_out_pin_q(clock_out_pin_q));
    rom_model i_rom (.sys_clk(sys_clk), .rom_rd(rom_rd_q), .rom_addr(rom_addr_q),
        .rom_data(rom_data));
    always #50 sys_clk = ~sys_clk;
    // sample just after the edge so the design's updates have landed
    task automatic tick();
        @(posedge sys_clk);
        #1;
    endtask : tick
    task automatic check(input logic ok, input string msg);
        n_tests++;
        if (ok !== 1'b1) begin
            num_errors++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask : check
    // wait for the next executed word and compare its address
    task automatic next_instr(input logic [11:0] exp, input string msg);
        logic [14:0] prev;
        prev = instr_q;
        for (gap = 0; gap < 40; gap++) begin
            if (instr_valid_q === 1'b1 && instr_q !== prev) break;
            tick();
        end
        cur = instr_q[11:0];
        check(instr_q === {3'h5, exp}, msg);
    endtask : next_instr
    task automatic idle_inputs();
        @(posedge sys_clk);
        load_kind <= 3'h0;
        {ext_irq, tmr0_irq, tmr1_irq, stack_full} <= 4'h0;
    endtask : idle_inputs
    // one execute-stage decision; judge dummy length, target and acknowledge
    task automatic reload(input logic [2:0] kind, input logic [11:0] arg,
                          input logic [2:0] irq, input logic full);
        logic [11:0] nx, exp;
        logic        vec, acked;
        int          lo;
        next_instr(cur + 12'h001, "sequential word");
        nx = cur + 12'h001;
        vec = (irq != 3'h0) && !full;
        exp = (kind == 3'h1 || kind == 3'h2) ? arg : (kind == 3'h3) ? {nx[11:8], arg[7:0]}
            : (kind == 3'h4) ? cur + seq_pkg::SKIP_STEP : nx;
        if (vec) exp = irq[2] ? seq_pkg::EXT_VEC : irq[1] ? seq_pkg::TMR0_VEC : seq_pkg::TMR1_VEC;
        @(posedge sys_clk);
        load_kind <= kind;
        jump_target <= arg;
        stack_top <= arg;
        low_byte_data <= arg[7:0];
        {ext_irq, tmr0_irq, tmr1_irq, stack_full} <= {irq, full};
        acked = 1'b0;
        if (kind == 3'h0 && !vec) begin
            next_instr(nx, "refused request");
            idle_inputs();
        end else begin
            for (lo = 0; lo < 12 && instr_valid_q !== 1'b0; lo++) begin
                tick();
                acked |= irq_ack_q;
            end
            idle_inputs();
            #1;
            for (lo = 1; lo < 12 && instr_valid_q !== 1'b1; lo++) begin
                acked |= irq_ack_q;
                tick();
            end
            check(lo == 4, "dummy cycle length");
            check(instr_q === {3'h5, exp}, "reload target");
            check(acked === vec, "interrupt acknowledge");
            cur = exp;
        end
    endtask : reload
    task automatic clk_out();
        int n, hi, r;
        logic prev;
        @(posedge sys_clk);
        rc_osc_sel <= 1'b1;
        repeat (3) tick();
        hi = 0;
        r = 0;
        prev = clock_out_pin_q;
        for (n = 0; n < 16; n++) begin
            tick();
            hi += (clock_out_pin_q === 1'b1);
            r += (clock_out_pin_q === 1'b1 && prev !== 1'b1);
            prev = clock_out_pin_q;
        end
        check(hi == 8 && r == 4, "clock out not quarter rate");
        @(posedge sys_clk);
        rc_osc_sel <= 1'b0;
        repeat (3) tick();
        check(clock_out_pin_q === 1'b0, "clock out without rc option");
    endtask : clk_out
    task automatic doze();
        int n;
        @(posedge sys_clk);
        halt_req <= 1'b1;
        @(posedge sys_clk);
        halt_req <= 1'b0;
        for (n = 0; n < 12 && sleeping_q !== 1'b1; n++) tick();
        repeat (12) tick();
        check(sleeping_q === 1'b1 && rom_rd_q === 1'b0, "not asleep");
        @(posedge sys_clk);
        wake_req <= 1'b1;
        #1;
        for (n = 0; n < 40 && sleeping_q !== 1'b0; n++) tick();
        check(n >= WAKE && n <= WAKE + 6, "start-up length");
        wake_req <= 1'b0;
        for (n = 0; n < 20 && rom_rd_q !== 1'b1; n++) tick();
        check(n < 20, "no fetch after wake");
    endtask : doze
    task automatic pin_reset();
        @(posedge sys_clk);
        reset_n_pin <= 1'b0;
        repeat (4) tick();
        repeat (8) begin
            tick();
            check(instruction_pointer_q === 12'h000 && rom_rd_q === 1'b0, "pin hold");
        end
        @(posedge sys_clk);
        reset_n_pin <= 1'b1;
        #1;
        next_instr(seq_pkg::RESET_ADDR, "start after pin reset");
    endtask : pin_reset
    task automatic finish_test();
        if (num_errors == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : finish_test
    initial begin
        #(6000 * 100);
        num_errors++;
        finish_test();
    end
    initial begin
        {sys_clk, rst_n, rc_osc_sel, halt_req, wake_req, load_kind} = 8'h00;
        {reset_n_pin, jump_target, stack_top, low_byte_data} = 33'h100000000;
        {ext_irq, tmr0_irq, tmr1_irq, stack_full} = 4'h0;
        {num_errors, n_tests, cur} = '0;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        next_instr(12'h000, "first word after reset");
        next_instr(12'h001, "second word");
        check(gap == 4, "instruction cycle length");
        reload(3'h1, 12'h3a0, 3'h0, 1'b0);
        reload(3'h3, 12'h055, 3'h0, 1'b0);
        reload(3'h4, 12'h000, 3'h0, 1'b0);
        reload(3'h2, 12'h123, 3'h0, 1'b0);
        reload(3'h1, 12'hfff, 3'h0, 1'b0);
        reload(3'h0, 12'h000, 3'h4, 1'b0);
        reload(3'h0, 12'h000, 3'h2, 1'b0);
        reload(3'h0, 12'h000, 3'h1, 1'b0);
        reload(3'h1, 12'h200, 3'h7, 1'b0);
        reload(3'h0, 12'h000, 3'h4, 1'b1);
        clk_out();
        doze();
        pin_reset();
        finish_test();
    end
endmodule : instruction_sequencer_pc_tb_top
bind instruction_sequencer_pc instruction_sequencer_pc_asserts #(.WAKE_CLKS(WAKE_CLKS)) u_chk (
    .sys_clk(sys_clk), .rst_n(rst_n), .reset_n_pin(reset_n_pin), .rc_osc_sel(rc_osc_sel),
    .wake_req(wake_req), .load_kind(load_kind), .jump_target(jump_target),
    .ext_irq(ext_irq), .tmr0_irq(tmr0_irq), .tmr1_irq(tmr1_irq), .stack_full(stack_full),
    .rom_addr_q(rom_addr_q), .rom_rd_q(rom_rd_q), .instr_valid_q(instr_valid_q),
    .instruction_pointer_q(instruction_pointer_q), .irq_ack_q(irq_ack_q),
    .sleeping_q(sleeping_q), .clock_out_pin_q(clock_out_pin_q));
